// ==== hw/wbpr_pkg.sv ====
// package: register map, field positions, reset values and state types of the pipe reuse control
//------------------------------------------------------------
//------------------------------------------------------------
package wbpr_pkg;

    //------------------------------------------------------------
    // register map
    //------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_WRITEBACK_ATTR = 8'h00; // writeback_attr_reg
    localparam logic [7:0] ADDR_VIDEO_PIPE_ATTR = 8'h04; // video_pipe_attr_reg
    localparam logic [7:0] ADDR_STATUS = 8'h08; // status and sticky flag

    //------------------------------------------------------------
    // field positions
    //------------------------------------------------------------
    localparam int STORE_ENABLE_BIT = 0;
    localparam int MEM_TO_MEM_SELECT_BIT = 19;
    localparam int PIPE_ENABLE_BIT = 0;
    localparam int PIPE_ROUTE_BIT = 1; // 0 toward frame store, 1 toward panel
    localparam int ST_SYNC_LOST_BIT = 0; // write one to clear
    localparam int ST_COPY_RUN_BIT = 1;
    localparam int ST_PANEL_FETCH_BIT = 2;
    localparam int ST_PIPE_BOUND_BIT = 3;
    localparam int ST_FRAME_CORRUPT_BIT = 4;

    //------------------------------------------------------------
    // reset values
    //------------------------------------------------------------
    localparam logic RST_STORE_ENABLE = 1'b0;
    localparam logic RST_MEM_TO_MEM_SELECT = 1'b0;
    localparam logic RST_PIPE_ENABLE = 1'b0;
    localparam logic RST_PIPE_ROUTE = 1'b0;
    localparam logic [31:0] RST_READ_DATA = 32'h0000_0000;

    //------------------------------------------------------------
    // state types
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        COPY_IDLE = 2'b01,
        COPY_RUN = 2'b10
    } wbpr_copy_state_type;

    typedef enum logic [2:0] {
        GATE_OFF = 3'b001,
        GATE_WAIT = 3'b010,
        GATE_LIVE = 3'b100
    } wbpr_gate_state_type;

endpackage : wbpr_pkg

// ==== hw/wbpr_copy_seq.sv ====
// module: memory copy sequencer of the frame store path
`timescale 1ns/1ps
module wbpr_copy_seq
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic copy_request, // enable, memory copy mode and pipe toward store
    input wire logic copy_done, // one-cycle pulse: memory copy finished
    output logic copy_run, // copy in progress
    output logic copy_finish // one-cycle pulse: completion taken
);

    wbpr_pkg::wbpr_copy_state_type state;
    wbpr_pkg::wbpr_copy_state_type next_state;

    // completion counts only while running and still requested
    assign copy_finish = (state == wbpr_pkg::COPY_RUN) && copy_request && copy_done;
    assign copy_run = (state == wbpr_pkg::COPY_RUN);

    // next state: start on request, leave on completion or withdrawal
    always_comb
    begin
        next_state = state;
        unique case (state)
            wbpr_pkg::COPY_IDLE:
            begin
                if (copy_request)
                    next_state = wbpr_pkg::COPY_RUN;
            end
            wbpr_pkg::COPY_RUN:
            begin
                if (!copy_request || copy_done)
                    next_state = wbpr_pkg::COPY_IDLE;
            end
            default: next_state = wbpr_pkg::COPY_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            state <= wbpr_pkg::COPY_IDLE;
        else
            state <= next_state;
    end

endmodule : wbpr_copy_seq

// ==== hw/wbpr_frame_gate.sv ====
// module: panel fetch gate aligning a video pipe to panel frame starts
`timescale 1ns/1ps
module wbpr_frame_gate
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic panel_request, // pipe enabled toward an active panel
    input wire logic join_unaligned, // one-cycle pulse: on-the-fly join
    input wire logic frame_start, // one-cycle pulse: panel frame start
    output logic panel_fetch, // pipe fetching for the panel
    output logic frame_corrupt // current panel frame is corrupted
);

    wbpr_pkg::wbpr_gate_state_type state;
    wbpr_pkg::wbpr_gate_state_type next_state;
    logic next_corrupt;

    assign panel_fetch = (state == wbpr_pkg::GATE_LIVE);

    // corrupt flag stands from an unaligned join to the next frame start
    assign next_corrupt = join_unaligned | (frame_corrupt & ~frame_start);

    // next state of the gate
    always_comb
    begin
        next_state = state;
        unique case (state)
            wbpr_pkg::GATE_OFF:
            begin
                if (panel_request && join_unaligned)
                    next_state = wbpr_pkg::GATE_LIVE;
                else if (panel_request)
                    next_state = wbpr_pkg::GATE_WAIT;
            end
            wbpr_pkg::GATE_WAIT:
            begin
                if (!panel_request)
                    next_state = wbpr_pkg::GATE_OFF;
                else if (frame_start)
                    next_state = wbpr_pkg::GATE_LIVE;
            end
            wbpr_pkg::GATE_LIVE:
            begin
                if (!panel_request)
                    next_state = wbpr_pkg::GATE_OFF;
            end
            default: next_state = wbpr_pkg::GATE_OFF;
        endcase
    end

    // state and corrupt registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state <= wbpr_pkg::GATE_OFF;
            frame_corrupt <= 1'b0;
        end
        else
        begin
            state <= next_state;
            frame_corrupt <= next_corrupt;
        end
    end

endmodule : wbpr_frame_gate

// ==== hw/wbpr_top.sv ====
// module: writeback pipe reuse control with register port and checks
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module wbpr_top
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire logic copy_done, // pulse: frame store copy finished
    input wire logic panel_active, // level: panel output running
    input wire logic panel_frame_start, // pulse: panel frame start
    output logic copy_run, // level: memory copy in progress
    output logic store_fetch, // level: pipe feeds the frame store
    output logic panel_fetch, // level: pipe feeds the panel
    output logic frame_corrupt, // level: current panel frame corrupted
    output logic sync_lost_pulse // pulse: sync lost raised
);

    //------------------------------------------------------------
    // register state
    //------------------------------------------------------------
    logic store_enable;
    logic mem_to_mem_select;
    logic pipe_enable;
    logic pipe_route;
    logic pipe_enable_q;
    logic panel_request_q;
    logic pipe_bound;
    logic release_armed;
    logic sync_lost;
    logic copy_finish;
    logic [31:0] next_rdata;

    //------------------------------------------------------------
    // address decode
    //------------------------------------------------------------
    wire wr_store_attr = reg_wr && (reg_addr == wbpr_pkg::ADDR_WRITEBACK_ATTR);
    wire wr_pipe = reg_wr && (reg_addr == wbpr_pkg::ADDR_VIDEO_PIPE_ATTR);
    wire wr_status = reg_wr && (reg_addr == wbpr_pkg::ADDR_STATUS);
    wire rd_store_attr = reg_rd && (reg_addr == wbpr_pkg::ADDR_WRITEBACK_ATTR);
    wire rd_pipe = reg_rd && (reg_addr == wbpr_pkg::ADDR_VIDEO_PIPE_ATTR);
    wire rd_status = reg_rd && (reg_addr == wbpr_pkg::ADDR_STATUS);

    //------------------------------------------------------------
    // next values of the control bits
    //------------------------------------------------------------
    // completion clears enable
    wire next_store_enable = wr_store_attr ? reg_wdata[wbpr_pkg::STORE_ENABLE_BIT] :
                             (copy_finish ? 1'b0 : store_enable);
    wire next_mem_to_mem_select = wr_store_attr ? reg_wdata[wbpr_pkg::MEM_TO_MEM_SELECT_BIT] :
                                  mem_to_mem_select;
    wire next_pipe_enable = wr_pipe ? reg_wdata[wbpr_pkg::PIPE_ENABLE_BIT] : pipe_enable;
    wire next_pipe_route = wr_pipe ? reg_wdata[wbpr_pkg::PIPE_ROUTE_BIT] : pipe_route;

    wire copy_request = store_enable && mem_to_mem_select && pipe_enable && !pipe_route;

    //------------------------------------------------------------
    // pipe binding and release
    //------------------------------------------------------------
    wire wr_pipe_enable_on = wr_pipe && reg_wdata[wbpr_pkg::PIPE_ENABLE_BIT];
    wire release_arm = wr_store_attr && reg_wdata[wbpr_pkg::STORE_ENABLE_BIT] && !pipe_enable &&
                       pipe_bound;
    wire release_fire = wr_store_attr && !reg_wdata[wbpr_pkg::STORE_ENABLE_BIT] && release_armed;
    wire next_bound = copy_run | (pipe_bound & ~release_fire);
    wire next_armed = (release_armed | release_arm) & ~release_fire & ~wr_pipe_enable_on;

    //------------------------------------------------------------
    // join detection toward the panel
    //------------------------------------------------------------
    wire panel_request = pipe_enable && pipe_route && panel_active;
    wire panel_join = panel_request && !panel_request_q;
    wire join_unaligned = panel_join && (pipe_enable_q || pipe_bound);
    wire next_sync_lost = join_unaligned |
                          (sync_lost & ~(wr_status & reg_wdata[wbpr_pkg::ST_SYNC_LOST_BIT]));

    assign sync_lost_pulse = join_unaligned;
    assign store_fetch = copy_run;

    //------------------------------------------------------------
    // read data selection
    //------------------------------------------------------------
    wire [31:0] store_word = ({31'h0, store_enable} << wbpr_pkg::STORE_ENABLE_BIT) |
                             ({31'h0, mem_to_mem_select} << wbpr_pkg::MEM_TO_MEM_SELECT_BIT);
    wire [31:0] pipe_word = ({31'h0000_0000, pipe_enable} << wbpr_pkg::PIPE_ENABLE_BIT) |
                            ({31'h0000_0000, pipe_route} << wbpr_pkg::PIPE_ROUTE_BIT);
    wire [31:0] status_word = ({31'h0000_0000, sync_lost} << wbpr_pkg::ST_SYNC_LOST_BIT) |
                              ({31'h0000_0000, copy_run} << wbpr_pkg::ST_COPY_RUN_BIT) |
                              ({31'h0000_0000, panel_fetch} << wbpr_pkg::ST_PANEL_FETCH_BIT) |
                              ({31'h0000_0000, pipe_bound} << wbpr_pkg::ST_PIPE_BOUND_BIT) |
                              ({31'h0000_0000, frame_corrupt} << wbpr_pkg::ST_FRAME_CORRUPT_BIT);
    assign next_rdata = rd_store_attr ? store_word :
                        rd_pipe ? pipe_word :
                        rd_status ? status_word : 32'h0000_0000;

    //------------------------------------------------------------
    // sub blocks
    //------------------------------------------------------------
    // copy sequencer of the frame store path
    wbpr_copy_seq u_copy_seq
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .copy_request(copy_request),
        .copy_done(copy_done),
        .copy_run(copy_run),
        .copy_finish(copy_finish)
    );

    // frame start gate toward the panel
    wbpr_frame_gate u_frame_gate
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .panel_request(panel_request),
        .join_unaligned(join_unaligned),
        .frame_start(panel_frame_start),
        .panel_fetch(panel_fetch),
        .frame_corrupt(frame_corrupt)
    );

    //------------------------------------------------------------
    // register updates
    //------------------------------------------------------------
    // control bits and attribute fields
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            store_enable <= wbpr_pkg::RST_STORE_ENABLE;
            mem_to_mem_select <= wbpr_pkg::RST_MEM_TO_MEM_SELECT;
            pipe_enable <= wbpr_pkg::RST_PIPE_ENABLE;
            pipe_route <= wbpr_pkg::RST_PIPE_ROUTE;
        end
        else
        begin
            store_enable <= next_store_enable;
            mem_to_mem_select <= next_mem_to_mem_select;
            pipe_enable <= next_pipe_enable;
            pipe_route <= next_pipe_route;
        end
    end

    // history, binding and sticky flag
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pipe_enable_q <= 1'b0;
            panel_request_q <= 1'b0;
            pipe_bound <= 1'b0;
            release_armed <= 1'b0;
            sync_lost <= 1'b0;
        end
        else
        begin
            pipe_enable_q <= pipe_enable;
            panel_request_q <= panel_request;
            pipe_bound <= next_bound;
            release_armed <= next_armed;
            sync_lost <= next_sync_lost;
        end
    end

    // read data register
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= wbpr_pkg::RST_READ_DATA;
        else
            reg_rdata <= next_rdata;
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    // copy mode start
    a_copy_mode_start: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(copy_run) |-> $past(store_enable && mem_to_mem_select && !pipe_route))
        else $error("copy started without memory copy mode");

    a_store_enable_clear: assert property (
        @(posedge sys_clk) disable iff (srst)
        (copy_finish && !wr_store_attr) |=> (!store_enable && !copy_run))
        else $error("frame store enable not cleared at completion");

    a_pipe_enable_kept: assert property (
        @(posedge sys_clk) disable iff (srst)
        (copy_finish && !wr_pipe) |=> (pipe_enable && pipe_bound))
        else $error("pipe enable changed at completion");

    a_unaligned_join: assert property (
        @(posedge sys_clk) disable iff (srst)
        join_unaligned |=> (panel_fetch && frame_corrupt && sync_lost))
        else $error("unaligned join without corruption and sync lost");

    a_corrupt_window: assert property (
        @(posedge sys_clk) disable iff (srst)
        (frame_corrupt && panel_frame_start && !join_unaligned) |=> !frame_corrupt)
        else $error("corrupt flag outlived the frame");

    a_fetch_aligned: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(panel_fetch) |-> $past(panel_frame_start || join_unaligned))
        else $error("panel fetch began off a frame start");

    a_sync_lost_hold: assert property (
        @(posedge sys_clk) disable iff (srst)
        (sync_lost && !wr_status) |=> sync_lost)
        else $error("sync lost flag dropped without clear");

    a_status_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        rd_status |=> (reg_rdata[wbpr_pkg::ST_SYNC_LOST_BIT] == $past(sync_lost)))
        else $error("status read data wrong");

    a_exit_release: assert property (
        @(posedge sys_clk) disable iff (srst)
        (release_fire && !copy_run) |=> !pipe_bound)
        else $error("pipe binding not released by exit sequence");

    a_clean_rejoin: assert property (
        @(posedge sys_clk) disable iff (srst)
        (panel_join && !pipe_enable_q && !pipe_bound && !panel_frame_start) |=> !panel_fetch)
        else $error("clean join fetched before frame start");

    a_copy_idle_hold: assert property (
        @(posedge sys_clk) disable iff (srst)
        (!copy_run && !copy_request) |=> !copy_run)
        else $error("copy started without a request");

    a_start_needs_pipe: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(copy_run) |-> $past(pipe_enable))
        else $error("copy started with the pipe disabled");

    a_copy_run_hold: assert property (
        @(posedge sys_clk) disable iff (srst)
        (copy_run && copy_request && !copy_done) |=> copy_run)
        else $error("copy ended before completion");

    a_status_copy_bit: assert property (
        @(posedge sys_clk) disable iff (srst)
        rd_status |=> (reg_rdata[wbpr_pkg::ST_COPY_RUN_BIT] == $past(copy_run)))
        else $error("status copy bit wrong");

    a_copy_binds_pipe: assert property (
        @(posedge sys_clk) disable iff (srst)
        copy_run |=> pipe_bound)
        else $error("pipe not bound during copy");

    a_finish_keeps_route: assert property (
        @(posedge sys_clk) disable iff (srst)
        (copy_finish && !wr_pipe) |=> !pipe_route)
        else $error("pipe route changed at completion");

    a_fetch_needs_request: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(panel_fetch) |-> $past(panel_request))
        else $error("panel fetch began without a request");

    a_fetch_drop: assert property (
        @(posedge sys_clk) disable iff (srst)
        (panel_fetch && !panel_request) |=> !panel_fetch)
        else $error("panel fetch outlived its request");

    a_wait_no_fetch: assert property (
        @(posedge sys_clk) disable iff (srst)
        (!panel_fetch && !panel_frame_start && !join_unaligned) |=> !panel_fetch)
        else $error("panel fetch began without frame start");

    a_sync_lost_clear: assert property (
        @(posedge sys_clk) disable iff (srst)
        (sync_lost && wr_status && reg_wdata[wbpr_pkg::ST_SYNC_LOST_BIT] && !join_unaligned)
        |=> !sync_lost)
        else $error("sync lost flag not cleared by write");

    a_status_fetch_bit: assert property (
        @(posedge sys_clk) disable iff (srst)
        rd_status |=> (reg_rdata[wbpr_pkg::ST_PANEL_FETCH_BIT] == $past(panel_fetch)))
        else $error("status fetch bit wrong");

endmodule : wbpr_top

// ==== verif/wbpr_far_model.sv ====
// partner model: copy engine completion and a running panel
`timescale 1ns/1ps
module wbpr_far_model
#(
    parameter int COPY_LAT = 6, // copy lasts COPY_LAT + 1 = 7 cycles before completion
    parameter int FRAME_LEN = 24 // cycles per panel frame
)
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic srst, // synchronous reset, active high
    input wire logic store_fetch, // pipe feeds the frame store
    output logic copy_done, // pulse: copy finished
    output logic panel_active, // level: panel running
    output logic panel_frame_start // pulse: panel frame start
);
    int copy_cnt;
    int frame_cnt;

    // copy engine finishes a fixed time after the pipe starts feeding
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            copy_cnt <= 0;
            copy_done <= 1'b0;
        end
        else
        begin
            copy_done <= 1'b0;
            copy_cnt <= 0;
            if (store_fetch && !copy_done)
            begin
                copy_cnt <= copy_cnt + 1;
                if (copy_cnt == COPY_LAT)
                begin
                    copy_done <= 1'b1;
                    copy_cnt <= 0;
                end
            end
        end
    end

    // panel runs free after reset with a periodic frame start
    always_ff @(posedge sys_clk)
    begin
        panel_active <= !srst;
        panel_frame_start <= 1'b0;
        frame_cnt <= srst ? 0 : (frame_cnt == FRAME_LEN - 1 ? 0 : frame_cnt + 1);
        if (!srst && frame_cnt == FRAME_LEN - 1)
        begin
            panel_frame_start <= 1'b1;
        end
    end
endmodule : wbpr_far_model

// ==== verif/test_wbpr_top.sv ====
// testbench: register sequences for copy completion, on-the-fly join and clean exit
`timescale 1ns/1ps
module test_wbpr_top;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    logic copy_done, panel_active, panel_frame_start, copy_run, store_fetch;
    logic panel_fetch, frame_corrupt, sync_lost_pulse, fs_before;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_sync = 0;
    int cycles = 0;

    always #2.5 sys_clk = ~sys_clk;

    wbpr_top dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .copy_done(copy_done),
        .panel_active(panel_active), .panel_frame_start(panel_frame_start),
        .copy_run(copy_run), .store_fetch(store_fetch), .panel_fetch(panel_fetch),
        .frame_corrupt(frame_corrupt), .sync_lost_pulse(sync_lost_pulse));

    wbpr_far_model far (.sys_clk(sys_clk), .srst(srst), .store_fetch(store_fetch),
        .copy_done(copy_done), .panel_active(panel_active),
        .panel_frame_start(panel_frame_start));

    //------------------------------------------------------------
    // bus tasks and checks
    //------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // bounded wait for copy_run (0), frame_corrupt (1) or panel_fetch (2)
    task automatic wait_sig(input int sel, input logic val);
        logic pick;
        for (int i = 0; i < 200; i++)
        begin
            @(posedge sys_clk);
            #1;
            pick = (sel == 0) ? copy_run : (sel == 1) ? frame_corrupt : panel_fetch;
            if (pick === val)
                return;
            fs_before = panel_frame_start;
        end
        check("wait", 32'h1, 32'h0);
    endtask : wait_sig

    task automatic do_copy;
        wr(8'h04, 32'h0000_0001);
        wr(8'h00, 32'h0008_0001);
        wait_sig(0, 1'b1);
        check("store_fetch", 32'h1, {31'h0, store_fetch});
        wait_sig(0, 1'b0);
    endtask : do_copy

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // sync-lost pulse monitor and run ceiling
    always @(posedge sys_clk)
    begin
        cycles++;
        if (sync_lost_pulse === 1'b1)
            n_sync++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        rd(8'h00);
        check("store_attr_reset", 32'h0, rv);
        rd(8'h04);
        check("pipe_attr_reset", 32'h0, rv);
        rd(8'h0C);
        check("unmapped", 32'h0, rv);
        $display("test reset done");
        do_copy();
        rd(8'h00);
        check("store_enable_cleared", 32'h0008_0000, rv);
        rd(8'h04);
        check("pipe_enable_kept", 32'h0000_0001, rv);
        rd(8'h08);
        check("status_bound", 32'h0000_0008, rv);
        $display("test copy done");
        wr(8'h04, 32'h0000_0003);
        rd(8'h08);
        check("sync_pulse", 32'h1, n_sync);
        check("sync_lost_flag", 32'h1, {31'h0, rv[0]});
        check("corrupt", 32'h1, {31'h0, rv[4]});
        check("fetch_unaligned", 32'h1, {31'h0, rv[2]});
        wait_sig(1, 1'b0);
        wr(8'h08, 32'h0000_0001);
        rd(8'h08);
        check("sync_lost_w1c", 32'h0, {31'h0, rv[0]});
        $display("test on the fly done");
        wr(8'h04, 32'h0000_0000);
        do_copy();
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_0001);
        wr(8'h00, 32'h0000_0000);
        rd(8'h08);
        check("status_after_exit", 32'h0, rv);
        wr(8'h04, 32'h0000_0002);
        wr(8'h04, 32'h0000_0003);
        #1;
        check("no_fetch_yet", 32'h0, {31'h0, panel_fetch});
        fs_before = 1'b0;
        wait_sig(2, 1'b1);
        check("fetch_after_frame_start", 32'h1, {31'h0, fs_before});
        check("clean_no_sync", 32'h1, n_sync);
        check("clean_no_corrupt", 32'h0, {31'h0, frame_corrupt});
        $display("test clean exit done");
        tally_and_finish();
    end
endmodule : test_wbpr_top
